// [src/csr_pkg.sv]
// Register map, field access codes and bus states of the identity bank
`default_nettype none
package csr_pkg;
  // Serial bus slave address of this device
  localparam logic [6:0] DEV_ADDR = 7'h20;

  // Identification and revision register offsets
  localparam logic [7:0] OFS_VENDOR_LOW   = 8'h00;
  localparam logic [7:0] OFS_VENDOR_HIGH  = 8'h01;
  localparam logic [7:0] OFS_PRODUCT_LOW  = 8'h02;
  localparam logic [7:0] OFS_PRODUCT_HIGH = 8'h03;
  localparam logic [7:0] OFS_PART_LOW     = 8'h04;
  localparam logic [7:0] OFS_PART_HIGH    = 8'h05;
  localparam logic [7:0] OFS_CONN_LOW     = 8'h06;
  localparam logic [7:0] OFS_CONN_HIGH    = 8'h07;
  localparam logic [7:0] OFS_PD_LOW       = 8'h08;
  localparam logic [7:0] OFS_PD_HIGH      = 8'h09;
  localparam logic [7:0] OFS_PIF_LOW      = 8'h0a;
  localparam logic [7:0] OFS_PIF_HIGH     = 8'h0b;
  // Command and event registers
  localparam logic [7:0] OFS_CMD_REQUEST  = 8'ha2;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'ha3;

  // Fixed revision values
  localparam logic [7:0] CONN_LOW_VAL  = 8'h11;
  localparam logic [7:0] CONN_HIGH_VAL = 8'h00;
  localparam logic [7:0] PD_LOW_VAL    = 8'h11;
  localparam logic [7:0] PD_HIGH_VAL   = 8'h20;
  localparam logic [7:0] PIF_LOW_VAL   = 8'h10;
  localparam logic [7:0] PIF_HIGH_VAL  = 8'h10;
  // Value returned by reserved locations
  localparam logic [7:0] RSVD_VAL      = 8'h00;

  // Values after reset
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [3:0] BITCNT_RESET = 4'h0;
  localparam logic       LINE_IDLE    = 1'b1;
  localparam logic       FIELD_RESET  = 1'b0;
  // Bits in one serial byte
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  // Field access behaviours, one flag each
  localparam logic [3:0] ACC_SET        = 4'h1;
  localparam logic [3:0] ACC_CLEAR      = 4'h2;
  localparam logic [3:0] ACC_AFTER_READ = 4'h4;
  localparam logic [3:0] ACC_UPDATE     = 4'h8;
  localparam logic [3:0] CMD_ACCESS = ACC_SET | ACC_UPDATE;
  localparam logic [3:0] EVT_ACCESS = ACC_CLEAR | ACC_AFTER_READ | ACC_UPDATE;

  // Serial slave states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_WDATA    = 3'b010,
    ST_WR_ACK   = 3'b110,
    ST_RDATA    = 3'b111,
    ST_RD_ACK   = 3'b101
  } bus_state_t;
endpackage
`default_nettype wire

// [src/pin_sync.sv]
// Two-stage synchroniser for pins from outside the clock domain
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Raw pins and their synchronised copy
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] pin_sync
);
  import csr_pkg::*;

  // First stage feeds only the second stage
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_t;

  sync_state_t st;       // Registered state
  sync_state_t next_st;  // Next state

  // Shift pins through both stages
  always_comb begin
    next_st.s1 = pin;
    next_st.s2 = st.s1;
  end

  // Idle bus lines float high, so reset to high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{s1: {WIDTH{LINE_IDLE}}, s2: {WIDTH{LINE_IDLE}}};
    end else begin
      st <= next_st;
    end
  end

  assign pin_sync = st.s2;
endmodule // pin_sync
`default_nettype wire

// [src/csr_bit.sv]
// One register field bit with selectable access behaviour
`default_nettype none
module csr_bit #(
  parameter logic [3:0] ACCESS = csr_pkg::ACC_SET
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Software access strobes
  input  wire logic sw_write,
  input  wire logic sw_data,
  input  wire logic sw_read,
  // Hardware update strobes
  input  wire logic hw_set,
  input  wire logic hw_clear,
  // Field value
  output logic      value
);
  import csr_pkg::*;

  typedef struct packed {
    logic value;
  } bit_state_t;

  bit_state_t st;       // Registered field
  bit_state_t next_st;  // Next field value

  // Clears are applied first so a set in the same cycle wins
  always_comb begin
    next_st = st;
    if ((ACCESS & ACC_CLEAR) != 4'h0 && sw_write && sw_data) begin
      next_st.value = 1'b0;
    end
    if ((ACCESS & ACC_AFTER_READ) != 4'h0 && sw_read) begin
      next_st.value = 1'b0;
    end
    if ((ACCESS & ACC_UPDATE) != 4'h0 && hw_clear) begin
      next_st.value = 1'b0;
    end
    if ((ACCESS & ACC_SET) != 4'h0 && sw_write && sw_data) begin
      next_st.value = 1'b1;
    end
    if ((ACCESS & ACC_UPDATE) != 4'h0 && hw_set) begin
      next_st.value = 1'b1;
    end
  end

  // Field register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{value: FIELD_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign value = st.value;
endmodule // csr_bit
`default_nettype wire

// [src/pd_port_identity_csr.sv]
// Serial slave with identification, revision and event registers
//
// Summary of operation
// - Writing one sets a set-type field
// - Writing one clears a clear-type field
// - Reading clears a clear-after-read field
// - Hardware may update update-type fields anytime
// - Reserved locations read as zero
// - Reserved writes acknowledged, data dropped
// - Vendor code low then high byte
// - Product code at third and fourth
// - Part code at fifth and sixth
// - Connector revision low byte reads 0x11
// - Power delivery revision reads 0x11, 0x20
// - Port interface revision bytes read 0x10
`default_nettype none
module pd_port_identity_csr #(
  parameter logic [15:0] VENDOR_CODE  = 16'h5a3c, // Arbitrary value
  parameter logic [15:0] PRODUCT_CODE = 16'h6b2d, // Arbitrary value
  parameter logic [15:0] PART_CODE    = 16'h7e19  // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Serial host bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Hardware side of the command register
  input  wire logic [7:0] cmd_done,
  output logic      [7:0] cmd_request,
  // Hardware side of the event register
  input  wire logic [7:0] event_in,
  output logic      [7:0] event_status
);
  import csr_pkg::*;

  // Whole slave state in one record
  typedef struct packed {
    bus_state_t  st;      // Protocol state
    logic        scl_q;   // Previous synchronised clock
    logic        sda_q;   // Previous synchronised data
    logic [7:0]  shreg;   // Shift register, in or out
    logic [3:0]  bitcnt;  // Bits seen in this byte
    logic [7:0]  ptr;     // Register pointer
    logic        first;   // Next written byte is the pointer
    logic        rw;      // Transfer direction, high reads
    logic        sda_oe;  // Pull data line low
    logic        sda_out; // Level driven when enabled
  } slave_state_t;

  slave_state_t st;       // Registered state
  slave_state_t next_st;  // Next state

  logic       scl_s;      // Synchronised clock line
  logic       sda_s;      // Synchronised data line
  logic       rise;       // Clock rising edge
  logic       fall;       // Clock falling edge
  logic       start_cond; // Start or repeated start
  logic       stop_cond;  // Stop
  logic       wr_en;      // Data byte written at ptr
  logic       load;       // Byte fetched at ptr for reading
  logic [7:0] rd_data;    // Read multiplexer output

  // Both bus lines come from another party, so synchronise them
  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .pin      ({scl_in, sda_in}),
    .pin_sync ({scl_s, sda_s})
  );

  // Line events, seen on synchronised copies only
  assign rise       = scl_s && !st.scl_q;
  assign fall       = !scl_s && st.scl_q;
  assign start_cond = scl_s && st.scl_q && st.sda_q && !sda_s;
  assign stop_cond  = scl_s && st.scl_q && !st.sda_q && sda_s;

  // Write strobe: any data byte after the pointer byte is acked
  assign wr_en = fall && st.st == ST_WDATA && st.bitcnt == BYTE_BITS
                 && !st.first;

  // Fetch at the end of the address ack or of a master ack
  assign load = fall && ((st.st == ST_ADDR_ACK && st.rw)
                         || st.st == ST_RD_ACK);

  // Read multiplexer; identity bytes are constants, not flops
  always_comb begin
    case (st.ptr)
      OFS_VENDOR_LOW:   rd_data = VENDOR_CODE[7:0];
      OFS_VENDOR_HIGH:  rd_data = VENDOR_CODE[15:8];
      OFS_PRODUCT_LOW:  rd_data = PRODUCT_CODE[7:0];
      OFS_PRODUCT_HIGH: rd_data = PRODUCT_CODE[15:8];
      OFS_PART_LOW:     rd_data = PART_CODE[7:0];
      OFS_PART_HIGH:    rd_data = PART_CODE[15:8];
      OFS_CONN_LOW:     rd_data = CONN_LOW_VAL;
      OFS_CONN_HIGH:    rd_data = CONN_HIGH_VAL;
      OFS_PD_LOW:       rd_data = PD_LOW_VAL;
      OFS_PD_HIGH:      rd_data = PD_HIGH_VAL;
      OFS_PIF_LOW:      rd_data = PIF_LOW_VAL;
      OFS_PIF_HIGH:     rd_data = PIF_HIGH_VAL;
      OFS_CMD_REQUEST:  rd_data = cmd_request;
      OFS_EVENT_STATUS: rd_data = event_status;
      default:          rd_data = RSVD_VAL;
    endcase
  end

  // Field bits: command is set-type, event is clear and read-clear
  for (genvar i = 0; i < 8; i++) begin : g_field
    // Software sets, hardware clears when the command is taken
    csr_bit #(
      .ACCESS (CMD_ACCESS)
    ) u_cmd (
      .clock    (clock),
      .rst_n    (rst_n),
      .sw_write (wr_en && st.ptr == OFS_CMD_REQUEST),
      .sw_data  (st.shreg[i]),
      .sw_read  (1'b0),
      .hw_set   (1'b0),
      .hw_clear (cmd_done[i]),
      .value    (cmd_request[i])
    );
    // Hardware sets; write of one or a read clears
    csr_bit #(
      .ACCESS (EVT_ACCESS)
    ) u_evt (
      .clock    (clock),
      .rst_n    (rst_n),
      .sw_write (wr_en && st.ptr == OFS_EVENT_STATUS),
      .sw_data  (st.shreg[i]),
      .sw_read  (load && st.ptr == OFS_EVENT_STATUS),
      .hw_set   (event_in[i]),
      .hw_clear (1'b0),
      .value    (event_status[i])
    );
  end

  // Slave protocol; data changes only while the clock is low
  always_comb begin
    next_st         = st;
    next_st.scl_q   = scl_s;
    next_st.sda_q   = sda_s;
    next_st.sda_out = 1'b0;
    if (start_cond) begin
      // Start wins in any state, repeated start keeps the pointer
      next_st.st     = ST_ADDR;
      next_st.bitcnt = BITCNT_RESET;
      next_st.first  = 1'b1;
      next_st.sda_oe = 1'b0;
    end else if (stop_cond) begin
      // Stop releases the line
      next_st.st     = ST_IDLE;
      next_st.sda_oe = 1'b0;
    end else if (rise) begin
      case (st.st)
        // Sample incoming bits
        ST_ADDR, ST_WDATA: begin
          next_st.shreg  = {st.shreg[6:0], sda_s};
          next_st.bitcnt = st.bitcnt + 4'h1;
        end
        // Count outgoing bits
        ST_RDATA: begin
          next_st.bitcnt = st.bitcnt + 4'h1;
        end
        // A high level here is a master not-ack: read ends
        ST_RD_ACK: begin
          if (sda_s) begin
            next_st.st = ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (st.st)
        // Address byte complete: ack only our own address
        ST_ADDR: begin
          if (st.bitcnt == BYTE_BITS) begin
            if (st.shreg[7:1] == DEV_ADDR) begin
              next_st.sda_oe = 1'b1;
              next_st.rw     = st.shreg[0];
              next_st.st     = ST_ADDR_ACK;
            end else begin
              next_st.st = ST_IDLE;
            end
          end
        end
        // End of address ack
        ST_ADDR_ACK: begin
          next_st.bitcnt = BITCNT_RESET;
          if (st.rw) begin
            next_st.st = ST_RDATA;
          end else begin
            next_st.sda_oe = 1'b0;
            next_st.st     = ST_WDATA;
          end
        end
        // Every written byte is acked, wherever it lands
        ST_WDATA: begin
          if (st.bitcnt == BYTE_BITS) begin
            next_st.sda_oe = 1'b1;
            next_st.st     = ST_WR_ACK;
            if (st.first) begin
              next_st.ptr   = st.shreg;
              next_st.first = 1'b0;
            end else begin
              // Read-only and reserved targets just drop the data
              next_st.ptr = st.ptr + 8'h01;
            end
          end
        end
        // End of write ack
        ST_WR_ACK: begin
          next_st.sda_oe = 1'b0;
          next_st.bitcnt = BITCNT_RESET;
          next_st.st     = ST_WDATA;
        end
        // Shift out, release for the master ack after bit eight
        ST_RDATA: begin
          if (st.bitcnt == BYTE_BITS) begin
            next_st.sda_oe = 1'b0;
            next_st.st     = ST_RD_ACK;
          end else begin
            next_st.shreg  = {st.shreg[6:0], 1'b0};
            next_st.sda_oe = !st.shreg[6];
          end
        end
        // Master acked, send the next byte
        ST_RD_ACK: begin
          next_st.bitcnt = BITCNT_RESET;
          next_st.st     = ST_RDATA;
        end
        default: begin
        end
      endcase
      // Fetch overrides the shift register with the pointed byte
      if (load) begin
        next_st.shreg  = rd_data;
        next_st.sda_oe = !rd_data[7];
        next_st.ptr    = st.ptr + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{st: ST_IDLE, scl_q: LINE_IDLE, sda_q: LINE_IDLE,
              shreg: PTR_RESET, bitcnt: BITCNT_RESET, ptr: PTR_RESET,
              first: 1'b1, rw: 1'b0, sda_oe: 1'b0, sda_out: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Open-drain data pin, low whenever enabled
  assign sda_out = st.sda_out;
  assign sda_oe  = st.sda_oe;

  // Checks on the register behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence wr_byte_done;
    fall && st.st == ST_WDATA && st.bitcnt == BYTE_BITS;
  endsequence

  sequence evt_fetch;
    load && st.ptr == OFS_EVENT_STATUS && event_in == 8'h00;
  endsequence

  set_field_a: assert property (
    (wr_en && st.ptr == OFS_CMD_REQUEST) |=>
      ((cmd_request & $past(st.shreg)) == $past(st.shreg)) &&
      ((cmd_request & ~$past(st.shreg)) ==
       ($past(cmd_request) & ~$past(st.shreg) & ~$past(cmd_done))))
    else $error("command bit write did not set or keep");

  clear_field_a: assert property (
    (wr_en && st.ptr == OFS_EVENT_STATUS) |=>
      ((event_status & $past(st.shreg) & ~$past(event_in)) == 8'h00) &&
      ((event_status & ~$past(st.shreg)) ==
       (($past(event_status) | $past(event_in)) & ~$past(st.shreg))))
    else $error("event bit write-one clear misbehaved");

  read_clear_a: assert property (
    evt_fetch |=> event_status == 8'h00 &&
                  st.shreg == $past(event_status))
    else $error("event read did not return and clear");

  hw_update_a: assert property (
    (event_in != 8'h00) |=>
      (event_status & $past(event_in)) == $past(event_in))
    else $error("hardware event lost");

  reserved_zero_a: assert property (
    (load && st.ptr > OFS_PIF_HIGH && st.ptr != OFS_CMD_REQUEST &&
     st.ptr != OFS_EVENT_STATUS) |=> st.shreg == RSVD_VAL && st.sda_oe)
    else $error("reserved location read nonzero");

  write_ack_a: assert property (
    wr_byte_done |=> st.sda_oe && st.st == ST_WR_ACK &&
                     st.ptr == ($past(st.first) ? $past(st.shreg) :
                                $past(st.ptr) + 8'h01))
    else $error("written byte not acknowledged");

  vendor_read_a: assert property (
    (load && (st.ptr == OFS_VENDOR_LOW || st.ptr == OFS_VENDOR_HIGH))
    |=> st.shreg == ($past(st.ptr) == OFS_VENDOR_LOW ?
                     VENDOR_CODE[7:0] : VENDOR_CODE[15:8])
        && st.sda_oe == !st.shreg[7])
    else $error("vendor code byte wrong");

  product_read_a: assert property (
    (load && (st.ptr == OFS_PRODUCT_LOW || st.ptr == OFS_PRODUCT_HIGH))
    |=> st.shreg == ($past(st.ptr) == OFS_PRODUCT_LOW ?
                     PRODUCT_CODE[7:0] : PRODUCT_CODE[15:8]))
    else $error("product code byte wrong");

  part_read_a: assert property (
    (load && (st.ptr == OFS_PART_LOW || st.ptr == OFS_PART_HIGH))
    |=> st.shreg == ($past(st.ptr) == OFS_PART_LOW ?
                     PART_CODE[7:0] : PART_CODE[15:8]))
    else $error("part code byte wrong");

  conn_rev_a: assert property (
    (load && st.ptr == OFS_CONN_LOW) |=> st.shreg == 8'h11 ##0
    (st.ptr == OFS_CONN_HIGH))
    else $error("connector revision wrong");

  pd_rev_a: assert property (
    (load && (st.ptr == OFS_PD_LOW || st.ptr == OFS_PD_HIGH))
    |=> st.shreg == ($past(st.ptr) == OFS_PD_LOW ? 8'h11 : 8'h20))
    else $error("power delivery revision wrong");

  pif_rev_a: assert property (
    (load && (st.ptr == OFS_PIF_LOW || st.ptr == OFS_PIF_HIGH))
    |=> st.shreg == 8'h10)
    else $error("port interface revision wrong");

  id_stable_a: assert property (
    (st.ptr <= OFS_PIF_HIGH && $stable(st.ptr)) |-> $stable(rd_data))
    else $error("identity byte changed");

  // Data written over identity bytes must not leak into live fields
  id_write_drop_a: assert property (
    (wr_en && st.ptr <= OFS_PIF_HIGH) |=>
      cmd_request == ($past(cmd_request) & ~$past(cmd_done)) &&
      event_status == ($past(event_status) | $past(event_in)))
    else $error("identity write reached a field");
endmodule // pd_port_identity_csr
`default_nettype wire

// [testbench/test_pd_port_identity_csr.sv]
// Self-checking bench for the identity, command and event register bank
`default_nettype none
module test_pd_port_identity_csr;
  timeunit 1ns;
  timeprecision 100ps;
  import csr_pkg::*;

  // Identity values handed to the design, arbitrary
  localparam logic [15:0] VC = 16'h3a7e;
  localparam logic [15:0] PC = 16'h4c91;
  localparam logic [15:0] DC = 16'h2b65;
  // Clock cycles per serial clock phase, above the minimum of 4
  localparam int          PH = 6;

  // Design pins
  logic       clock;
  logic       rst_n;
  logic       scl_in;
  logic       m_sda;        // Master drive, 1 = released
  wire logic  sda_in;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] cmd_done;
  logic [7:0] cmd_request;
  logic [7:0] event_in;
  logic [7:0] event_status;
  // Reference model and bookkeeping
  logic [7:0] m_cmd;
  logic [7:0] m_evt;
  logic [7:0] wq[$];        // Data bytes of the next write burst
  int         mismatches;
  int         cmp_count;
  logic       ack_seen;     // Acknowledge of a lone address byte

  // Open-drain wire: either party may pull low
  assign sda_in = m_sda & ~sda_oe;

  pd_port_identity_csr #(
    .VENDOR_CODE (VC),
    .PRODUCT_CODE(PC),
    .PART_CODE   (DC)
  ) uut (
    .clock       (clock),
    .rst_n       (rst_n),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_out     (sda_out),
    .sda_oe      (sda_oe),
    .cmd_done    (cmd_done),
    .cmd_request (cmd_request),
    .event_in    (event_in),
    .event_status(event_status)
  );

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  // Expected read value of each location from the model
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: return VC[7:0];
      8'h01: return VC[15:8];
      8'h02: return PC[7:0];
      8'h03: return PC[15:8];
      8'h04: return DC[7:0];
      8'h05: return DC[15:8];
      8'h06: return 8'h11;
      8'h07: return 8'h00;
      8'h08: return 8'h11;
      8'h09: return 8'h20;
      8'h0a: return 8'h10;
      8'h0b: return 8'h10;
      8'ha2: return m_cmd;
      8'ha3: return m_evt;
      default: return 8'h00;  // Reserved space reads zero
    endcase
  endfunction

  // Verdict, the only place the run ends
  task automatic tally_and_finish;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One comparison, counted
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  // Wait n rising edges, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Start or repeated start; sda rises only while scl is low
  task automatic bus_start;
    m_sda = 1'b1;
    cyc(PH);
    scl_in = 1'b1;
    cyc(PH);
    m_sda = 1'b0;
    cyc(PH);
    scl_in = 1'b0;
    cyc(PH);
  endtask

  // Stop condition, bus left idle high
  task automatic bus_stop;
    m_sda = 1'b0;
    cyc(PH);
    scl_in = 1'b1;
    cyc(PH);
    m_sda = 1'b1;
    cyc(PH);
  endtask

  // Eight bits MSB first, then sample the slave's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      m_sda = b[i];
      cyc(PH);
      scl_in = 1'b1;
      cyc(PH);
      scl_in = 1'b0;
    end
    m_sda = 1'b1;
    cyc(PH);
    scl_in = 1'b1;
    cyc(3);
    ack = ~sda_in;
    cyc(3);
    scl_in = 1'b0;
  endtask

  // Eight bits from the slave, then master ack or final nack
  task automatic recv_byte(input logic last, output logic [7:0] b);
    m_sda = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      cyc(PH);
      scl_in = 1'b1;
      cyc(3);
      b[i] = sda_in;
      cyc(3);
      scl_in = 1'b0;
    end
    m_sda = last;
    cyc(PH);
    scl_in = 1'b1;
    cyc(PH);
    scl_in = 1'b0;
  endtask

  // Write burst of wq at ptr; model follows after the stop
  task automatic wr_burst(input logic [7:0] ptr);
    logic       ack;
    logic [7:0] a;
    bus_start;
    send_byte({DEV_ADDR, 1'b0}, ack);
    chk("address ack", 8'h01, {7'h00, ack});
    send_byte(ptr, ack);
    chk("pointer ack", 8'h01, {7'h00, ack});
    foreach (wq[i]) begin
      send_byte(wq[i], ack);
      chk("data ack", 8'h01, {7'h00, ack});
    end
    bus_stop;
    foreach (wq[i]) begin
      a = ptr + 8'(i);
      if (a == 8'ha2) m_cmd = m_cmd | wq[i];
      if (a == 8'ha3) m_evt = m_evt & ~wq[i];
    end
  endtask

  // Read n bytes from ptr through a repeated start
  task automatic rd_burst(input logic [7:0] ptr, input int n);
    logic       ack;
    logic [7:0] b;
    logic [7:0] a;
    bus_start;
    send_byte({DEV_ADDR, 1'b0}, ack);
    send_byte(ptr, ack);
    bus_start;
    send_byte({DEV_ADDR, 1'b1}, ack);
    chk("read address ack", 8'h01, {7'h00, ack});
    for (int i = 0; i < n; i++) begin
      a = ptr + 8'(i);
      recv_byte(i == n - 1, b);
      chk("read byte", exp_rd(a), b);
      // Event register empties once fetched
      if (a == 8'ha3) m_evt = 8'h00;
    end
    bus_stop;
  endtask

  // Hardware strobes for one cycle, then model update
  task automatic hw_pulse(input logic [7:0] done, input logic [7:0] ev);
    cmd_done = done;
    event_in = ev;
    cyc(1);
    cmd_done = 8'h00;
    event_in = 8'h00;
    cyc(2);
    m_cmd = m_cmd & ~done;
    m_evt = m_evt | ev;
  endtask

  // Field outputs against the model
  task automatic chk_pins;
    chk("cmd_request", m_cmd, cmd_request);
    chk("event_status", m_evt, event_status);
    // Bus idle here, so the data line must be released
    chk("sda_oe", 8'h00, {7'h00, sda_oe});
    chk("sda_out", 8'h00, {7'h00, sda_out});
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    scl_in = 1'b1;
    m_sda = 1'b1;
    cmd_done = 8'h00;
    event_in = 8'h00;
    m_cmd = 8'h00;
    m_evt = 8'h00;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'h9147));
    cyc(8);
    rst_n = 1'b1;
    cyc(3);
    chk_pins;
    // Identity block, then two reserved bytes beyond it
    rd_burst(8'h00, 14);
    // Random writes over the identity block must not stick
    wq.delete();
    for (int i = 0; i < 12; i++) wq.push_back(8'($urandom));
    wr_burst(8'h00);
    rd_burst(8'h00, 12);
    // Reserved writes are acked and dropped
    wq = '{8'hff};
    wr_burst(8'h30);
    wr_burst(8'hf0);
    rd_burst(8'h30, 1);
    rd_burst(8'hf0, 1);
    // Foreign address is left unacknowledged
    bus_start;
    send_byte({DEV_ADDR ^ 7'h01, 1'b0}, ack_seen);
    chk("foreign address ack", 8'h00, {7'h00, ack_seen});
    bus_stop;
    // Random field traffic from both sides
    for (int k = 0; k < 8; k++) begin
      hw_pulse(8'($urandom), 8'($urandom));
      chk_pins;
      wq = '{8'($urandom)};
      wr_burst(8'ha2);
      wq = '{8'h00};
      wr_burst(8'ha2);
      wq = '{8'($urandom)};
      wr_burst(8'ha3);
      wq = '{8'h00};
      wr_burst(8'ha3);
      chk_pins;
      hw_pulse(8'h00, 8'($urandom));
      rd_burst(8'ha2, 2);
      chk_pins;
      rd_burst(8'ha3, 1);
    end
    // Second reset with live fields, identity still fixed
    wq = '{8'h5a};
    wr_burst(8'ha2);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    m_cmd = 8'h00;
    m_evt = 8'h00;
    cyc(3);
    rd_burst(8'h00, 12);
    chk_pins;
    tally_and_finish;
  end
endmodule // test_pd_port_identity_csr
`default_nettype wire
